/* File: mtt_pkg.sv */
// mtt_pkg: constants of the main timer timebase.
// assumes the core clock is the bus-phase clock of the timer.
package mtt_pkg;

  // ==========================================================
  // widths
  localparam int CNT_W    = 16;
  localparam int DIV_W    = 16;
  localparam int WDOG_W   = 7;
  localparam int SEL_W    = 2;
  localparam int NUM_CH   = 8;

  // ==========================================================
  // channel layout: 0..2 capture, 3 selectable, 4..7 compare
  localparam int FIRST_SEL_CH = 3;
  localparam int FIRST_CMP_CH = 4;

  // ==========================================================
  // timing figures, in bus-phase clock cycles (as exponents)
  localparam int PRESCALE_EXP_1  = 0;
  localparam int PRESCALE_EXP_4  = 2;
  localparam int PRESCALE_EXP_8  = 3;
  localparam int PRESCALE_EXP_16 = 4;
  localparam int PERIODIC_EXP_MIN = 13;
  localparam int WDOG_EXP_MIN     = 15;
  localparam int WDOG_EXP_STEP    = 2;
  localparam int WDOG_TOL_EXP     = 15;

  // ==========================================================
  // reset values
  localparam logic [CNT_W-1:0]  COUNT_RST = 16'h0000;
  localparam logic [DIV_W-1:0]  DIV_RST   = 16'h0000;
  localparam logic [WDOG_W-1:0] WDOG_RST  = 7'h00;
  localparam logic [7:0]        MON_RST   = 8'h00;

  // ==========================================================
  // clock monitor: this many core cycles or fewer per reference period
  // means the core clock is too slow
  localparam logic [7:0] CLKMON_MIN_CYCLES = 8'h10;

endpackage

/* File: mtt_count_if.sv */
// mtt_count_if: carries the free-running count to the channels.
// assumes one source (the timebase) and any number of channels.
`timescale 1ns/100ps
`default_nettype none

interface mtt_count_if;
  logic [15:0] count;   // current counter value
  logic        step;    // high the cycle after the count changed

  modport src  (output count, output step);
  modport chan (input count, input step);
endinterface

`default_nettype wire

/* File: mtt_channel.sv */
// mtt_channel: one capture/compare channel referenced to the counter.
// assumes the pin is asynchronous and the count arrives on the core clock.
`timescale 1ns/100ps
`default_nettype none

module mtt_channel
  import mtt_pkg::*;
#(
  parameter bit CAN_CAPTURE = 1'b1,
  parameter bit CAN_COMPARE = 1'b1
)(
  input  wire logic              core_clk_i,    // bus-phase clock
  input  wire logic              rstn_i,        // async reset, low
  mtt_count_if.chan              cnt,           // shared count
  input  wire logic              is_capture_i,  // 1 capture, 0 compare
  input  wire logic              pin_i,         // capture pin
  input  wire logic [CNT_W-1:0]  compare_i,     // compare value
  input  wire logic              flag_clear_i,  // clear event flag
  output logic      [CNT_W-1:0]  capture_o,     // latched count
  output logic                   flag_o,        // sticky event flag
  output logic                   pin_o          // compare output
);

  // ==========================================================
  // pin synchroniser, then edge detect on the second and third stages
  logic sync1_q, sync2_q, sync3_q;
  logic [CNT_W-1:0] capture_d;
  logic flag_d, pin_d, cap_evt, cmp_evt, capture_mode;

  always_comb
  begin
    capture_mode = CAN_CAPTURE && (!CAN_COMPARE || is_capture_i);
    cap_evt      = capture_mode && sync2_q && !sync3_q;               // [RULE3] [RULE4]
    cmp_evt      = !capture_mode && CAN_COMPARE && cnt.step
                   && (cnt.count == compare_i);                      // [RULE3] [RULE4]
    capture_d    = cap_evt ? cnt.count : capture_o;
    pin_d        = cmp_evt ? !pin_o : pin_o;
    // an event in the clearing cycle still lands
    flag_d       = (cap_evt || cmp_evt) || (flag_o && !flag_clear_i);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_q   <= 1'b0;
      sync2_q   <= 1'b0;
      sync3_q   <= 1'b0;
      capture_o <= COUNT_RST;
      flag_o    <= 1'b0;
      pin_o     <= 1'b0;
    end
    else
    begin
      sync1_q   <= pin_i;
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      capture_o <= capture_d;
      flag_o    <= flag_d;
      pin_o     <= pin_d;
    end
  end

endmodule

`default_nettype wire

/* File: mtt_timebase.sv */
// mtt_timebase: main timer timebase, periodic rate, watchdog, clock monitor.
// assumes control ports come from logic on the core clock; pins are async.
//
// How it works
// [RULE1] free 16-bit counter advanced by prescaler tick
// [RULE2] overflow reported so software counts wraps
// [RULE3] three capture, four compare channels on counter
// [RULE4] one channel selectable capture or compare
// [RULE5] clock monitor flags a too-slow core clock
// [RULE6] prescale select gives 1, 4, 8, 16 cycles
// [RULE7] periodic rate 2^13 to 2^16 cycles
// [RULE8] watchdog timeout 2^15, 2^17, 2^19, 2^21 cycles
// [RULE9] watchdog never early, at most 2^15 late
// [RULE10] counter clears on reset, read only
// [RULE11] wrap to zero sets sticky overflow flag
`timescale 1ns/100ps
`default_nettype none

module mtt_timebase
  import mtt_pkg::*;
#(
  parameter int NCH = NUM_CH
)(
  input  wire logic                       core_clk_i,               // bus-phase clock
  input  wire logic                       rstn_i,                   // async reset, low
  input  wire logic [mtt_pkg::SEL_W-1:0]  prescale_select_i,        // count tick rate
  input  wire logic [mtt_pkg::SEL_W-1:0]  periodic_rate_select_i,   // periodic rate
  input  wire logic [mtt_pkg::SEL_W-1:0]  watchdog_rate_select_i,   // watchdog timeout
  input  wire logic                       watchdog_enable_i,        // watchdog runs
  input  wire logic                       watchdog_service_i,       // restart watchdog
  input  wire logic                       overflow_clear_i,         // clear overflow flag
  input  wire logic                       periodic_clear_i,         // clear periodic flag
  input  wire logic                       channel_sel_capture_i,    // shared ch is capture
  input  wire logic [NCH-1:0]             capture_pin_i,            // capture pins
  input  wire logic [NCH-1:0][15:0]       compare_value_i,          // compare values
  input  wire logic [NCH-1:0]             channel_clear_i,          // clear channel flags
  input  wire logic                       clock_monitor_enable_i,   // monitor on
  input  wire logic                       monitor_ref_i,            // slow reference pin
  output logic      [mtt_pkg::CNT_W-1:0]  free_running_count_o,     // counter value
  output logic                            overflow_pulse_o,         // wrap this tick
  output logic                            overflow_flag_o,          // sticky wrap flag
  output logic                            periodic_interrupt_o,     // periodic pulse
  output logic                            periodic_flag_o,          // sticky periodic flag
  output logic                            watchdog_timeout_o,       // timeout pulse
  output logic                            clock_fail_o,             // sticky clock failure
  output logic      [NCH-1:0][15:0]       capture_value_o,          // captured counts
  output logic      [NCH-1:0]             channel_flag_o,           // channel flags
  output logic      [NCH-1:0]             compare_pin_o             // compare outputs
);

  // ==========================================================
  // divider chain and selected taps
  logic [DIV_W-1:0] div_q, div_d;
  logic [DIV_W-1:0] pre_mask, per_mask, wd_mask;
  logic             pre_tick, per_tick, wd_tick;

  always_comb
  begin
    unique case (prescale_select_i)                                  // [RULE6]
      2'h0: pre_mask = DIV_W'((1 << PRESCALE_EXP_1) - 1);
      2'h1: pre_mask = DIV_W'((1 << PRESCALE_EXP_4) - 1);
      2'h2: pre_mask = DIV_W'((1 << PRESCALE_EXP_8) - 1);
      2'h3: pre_mask = DIV_W'((1 << PRESCALE_EXP_16) - 1);
    endcase
    // 2^(13+sel)-1; the 2^16 case uses the full chain
    per_mask = DIV_W'((32'h1 << (PERIODIC_EXP_MIN + 32'(periodic_rate_select_i))) - 1); // [RULE7]
    wd_mask  = DIV_W'((32'h1 << WDOG_TOL_EXP) - 1);
    pre_tick = (div_q & pre_mask) == pre_mask;                       // [RULE1]
    per_tick = (div_q & per_mask) == per_mask;
    wd_tick  = (div_q & wd_mask) == wd_mask;
    div_d    = div_q + 16'h0001;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_q <= DIV_RST;
    else
      div_q <= div_d;
  end

  // ==========================================================
  // free-running counter and overflow
  logic [CNT_W-1:0] count_d;
  logic             ovf_evt, ovf_flag_d, step_q;

  always_comb
  begin
    ovf_evt    = pre_tick && (free_running_count_o == 16'hffff);    // [RULE11]
    count_d    = pre_tick ? free_running_count_o + 16'h0001
                          : free_running_count_o;                    // [RULE1] [RULE11]
    // set beats clear in the same cycle
    ovf_flag_d = ovf_evt || (overflow_flag_o && !overflow_clear_i); // [RULE2] [RULE11]
  end

  // no write path into the counter: software can only read it
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      free_running_count_o <= COUNT_RST;                             // [RULE10]
      overflow_pulse_o     <= 1'b0;
      overflow_flag_o      <= 1'b0;
      step_q               <= 1'b0;
    end
    else
    begin
      free_running_count_o <= count_d;
      overflow_pulse_o     <= ovf_evt;                               // [RULE2]
      overflow_flag_o      <= ovf_flag_d;
      step_q               <= pre_tick;
    end
  end

  // ==========================================================
  // periodic interrupt
  logic per_flag_d;

  always_comb
  begin
    per_flag_d = per_tick || (periodic_flag_o && !periodic_clear_i);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      periodic_interrupt_o <= 1'b0;
      periodic_flag_o      <= 1'b0;
    end
    else
    begin
      periodic_interrupt_o <= per_tick;                              // [RULE7]
      periodic_flag_o      <= per_flag_d;
    end
  end

  // ==========================================================
  // watchdog: counts 2^15-cycle ticks of the free chain; the chain is
  // not restarted by a service, so one extra tick is waited for, giving
  // a timeout between the period and the period plus 2^15 cycles
  logic [WDOG_W-1:0] wd_q, wd_d, wd_limit;
  logic              wd_fire;

  always_comb
  begin
    wd_limit = WDOG_W'((32'h1 << (WDOG_EXP_STEP * 32'(watchdog_rate_select_i)))
                       + 1);                                         // [RULE8] [RULE9]
    wd_fire  = 1'b0;
    wd_d     = wd_q;
    if (!watchdog_enable_i || watchdog_service_i)
      wd_d = WDOG_RST;
    else if (wd_tick)
    begin
      if (wd_q + 7'h01 == wd_limit)                                  // [RULE9]
      begin
        wd_fire = 1'b1;
        wd_d    = WDOG_RST;
      end
      else
        wd_d = wd_q + 7'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wd_q               <= WDOG_RST;
      watchdog_timeout_o <= 1'b0;
    end
    else
    begin
      wd_q               <= wd_d;
      watchdog_timeout_o <= wd_fire;                                 // [RULE8]
    end
  end

  // ==========================================================
  // clock monitor: counts core cycles per reference period; a stopped
  // or slowed core clock is the case the watchdog cannot see
  logic       ref1_q, ref2_q, ref3_q, ref_edge, seen_q, seen_d, fail_d;
  logic [7:0] mon_q, mon_d;

  always_comb
  begin
    ref_edge = ref2_q && !ref3_q;
    mon_d    = (mon_q == 8'hff) ? mon_q : mon_q + 8'h01;
    seen_d   = seen_q;
    fail_d   = clock_fail_o;
    if (!clock_monitor_enable_i)
    begin
      mon_d  = MON_RST;
      seen_d = 1'b0;
    end
    else if (ref_edge)
    begin
      // the first edge only starts the measurement
      if (seen_q && (mon_q < CLKMON_MIN_CYCLES))
        fail_d = 1'b1;                                               // [RULE5]
      mon_d  = MON_RST;
      seen_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref1_q       <= 1'b0;
      ref2_q       <= 1'b0;
      ref3_q       <= 1'b0;
      mon_q        <= MON_RST;
      seen_q       <= 1'b0;
      clock_fail_o <= 1'b0;
    end
    else
    begin
      ref1_q       <= monitor_ref_i;
      ref2_q       <= ref1_q;
      ref3_q       <= ref2_q;
      mon_q        <= mon_d;
      seen_q       <= seen_d;
      clock_fail_o <= fail_d;
    end
  end

  // ==========================================================
  // capture/compare channels
  mtt_count_if cnt_bus ();

  assign cnt_bus.count = free_running_count_o;
  assign cnt_bus.step  = step_q;

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    mtt_channel #(
      .CAN_CAPTURE (g <  FIRST_CMP_CH),                              // [RULE3] [RULE4]
      .CAN_COMPARE (g >= FIRST_SEL_CH)
    ) u_ch (
      .core_clk_i   (core_clk_i),
      .rstn_i       (rstn_i),
      .cnt          (cnt_bus),
      .is_capture_i (channel_sel_capture_i),
      .pin_i        (capture_pin_i[g]),
      .compare_i    (compare_value_i[g]),
      .flag_clear_i (channel_clear_i[g]),
      .capture_o    (capture_value_o[g]),
      .flag_o       (channel_flag_o[g]),
      .pin_o        (compare_pin_o[g])
    );
  end

endmodule

`default_nettype wire

/* File: mtt_timebase_props.sv */
// mtt_timebase_props: port-level timing checks of the timer timebase.
// assumes selects stay put while an interval is being measured.
`timescale 1ns/100ps
`default_nettype none

module mtt_timebase_props
  import mtt_pkg::*;
(
  input wire logic             core_clk_i,             // clock
  input wire logic             rstn_i,                 // reset, low
  input wire logic [SEL_W-1:0] prescale_select_i,      // tick rate
  input wire logic [SEL_W-1:0] periodic_rate_select_i, // periodic rate
  input wire logic [SEL_W-1:0] watchdog_rate_select_i, // watchdog rate
  input wire logic             watchdog_enable_i,      // watchdog on
  input wire logic             watchdog_service_i,     // restart
  input wire logic             overflow_clear_i,       // flag clear
  input wire logic [CNT_W-1:0] free_running_count_o,   // counter
  input wire logic             overflow_pulse_o,       // wrap pulse
  input wire logic             overflow_flag_o,        // wrap flag
  input wire logic             periodic_interrupt_o,   // periodic pulse
  input wire logic             periodic_flag_o,        // periodic flag
  input wire logic             watchdog_timeout_o,     // timeout
  input wire logic             clock_fail_o            // monitor fail
);
  // ==========================================================
  // cycles since last periodic pulse and last watchdog restart
  logic [31:0] gap_q, gap_d, wd_q, wd_d;
  logic        seen_q, seen_d;
  int          wd_n;
  always_comb
  begin
    gap_d  = periodic_interrupt_o ? 32'h1 : gap_q + 32'h1;
    seen_d = seen_q | periodic_interrupt_o;
    wd_d   = (!watchdog_enable_i || watchdog_service_i || watchdog_timeout_o)
             ? 32'h0 : wd_q + 32'h1;
    wd_n   = 1 << (2 * watchdog_rate_select_i);
  end
  always_ff @(posedge core_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
      wd_q   <= 32'h0;
    end
    else
    begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
      wd_q   <= wd_d;
    end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_count_step: assert property ($changed(free_running_count_o) |->
    free_running_count_o == 16'($past(free_running_count_o) + 16'h1))
    else $error("bad count step");
  // the edge leaving reset is skipped, though the count already steps on it
  a_tick_fast: assert property ($past(rstn_i) && $past(prescale_select_i) == 2'h0
    && prescale_select_i == 2'h0 |-> $changed(free_running_count_o))
    else $error("count missed a tick");
  // a select change may legally tick early, so only steady selects count
  a_tick_slow: assert property ($changed(free_running_count_o)
    && $stable(prescale_select_i) && prescale_select_i != 2'h0
    ##1 $stable(prescale_select_i) |-> !$changed(free_running_count_o))
    else $error("tick too fast");
  a_wrap_flag: assert property ($changed(free_running_count_o)
    && free_running_count_o == 16'h0 |-> overflow_flag_o) else $error("wrap without flag");
  a_flag_hold: assert property (overflow_flag_o && !overflow_clear_i
    |=> overflow_flag_o) else $error("overflow flag lost");
  a_flag_fall: assert property ($fell(overflow_flag_o) |-> $past(overflow_clear_i))
    else $error("overflow flag fell uncleared");
  a_ovf_pulse: assert property (overflow_pulse_o |-> free_running_count_o <= 16'h1
    ##1 !overflow_pulse_o) else $error("bad overflow pulse");
  a_periodic_gap: assert property (periodic_interrupt_o && seen_q |-> periodic_flag_o &&
    gap_q == (32'h1 << (13 + periodic_rate_select_i))) else $error("bad periodic spacing");
  a_wdog_window: assert property (watchdog_timeout_o |-> wd_q >= (wd_n << 15) &&
    wd_q <= ((wd_n + 1) << 15) + 2) else $error("watchdog fired outside window");
  a_fail_sticky: assert property (clock_fail_o |=> clock_fail_o)
    else $error("clock fail not sticky");
endmodule

bind mtt_timebase mtt_timebase_props u_props (
  .core_clk_i, .rstn_i, .prescale_select_i, .periodic_rate_select_i,
  .watchdog_rate_select_i, .watchdog_enable_i, .watchdog_service_i, .overflow_clear_i,
  .free_running_count_o, .overflow_pulse_o, .overflow_flag_o, .periodic_interrupt_o,
  .periodic_flag_o, .watchdog_timeout_o, .clock_fail_o
);

`default_nettype wire

/* File: mtt_timebase_tb.sv */
// mtt_timebase_tb: self-checking bench of the timer timebase.
// assumes the port checker is bound in from its own file.
`timescale 1ns/100ps
`default_nettype none

module mtt_timebase_tb;
  import mtt_pkg::*;
  // ==========================================================
  // stimulus and observed outputs
  logic             clk = 1'b0;
  logic             rstn, wd_en, wd_srv, ovf_clr, per_clr, ch_sel, mon_en, mon_ref;
  logic [1:0]       sel_p, sel_r, sel_w;
  logic [7:0]       cap_pin, ch_clr, ch_flag, cmp_pin;
  logic [7:0][15:0] cmp_val, cap_val;
  logic [15:0]      cnt;
  logic             ovf_p, ovf_f, per_i, per_f, wd_to, clk_fail;
  int               n_mismatch = 0;
  int               total_checks = 0;

  mtt_timebase uut (
    .core_clk_i(clk), .rstn_i(rstn), .prescale_select_i(sel_p),
    .periodic_rate_select_i(sel_r), .watchdog_rate_select_i(sel_w),
    .watchdog_enable_i(wd_en), .watchdog_service_i(wd_srv), .overflow_clear_i(ovf_clr),
    .periodic_clear_i(per_clr), .channel_sel_capture_i(ch_sel), .capture_pin_i(cap_pin),
    .compare_value_i(cmp_val), .channel_clear_i(ch_clr), .clock_monitor_enable_i(mon_en),
    .monitor_ref_i(mon_ref), .free_running_count_o(cnt), .overflow_pulse_o(ovf_p),
    .overflow_flag_o(ovf_f), .periodic_interrupt_o(per_i), .periodic_flag_o(per_f),
    .watchdog_timeout_o(wd_to), .clock_fail_o(clk_fail), .capture_value_o(cap_val),
    .channel_flag_o(ch_flag), .compare_pin_o(cmp_pin)
  );

  initial forever #4 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rstn = 1'b0;
    cyc(3);
    chk("count in reset", 0, cnt);
    chk("flag in reset", 0, ovf_f);
    rstn = 1'b1;
    cyc(1);
    chk("first count", 1, cnt);
  endtask

  task automatic t_prescale();
    int          n;
    logic [15:0] c0;
    for (int s = 0; s < 4; s++)
    begin
      sel_p = 2'(s);
      repeat (3)
      begin
        c0 = cnt;
        n = 0;
        while (cnt === c0 && n < 40)
        begin
          cyc(1);
          n++;
        end
      end
      chk("tick period", 1 << (s == 0 ? 0 : s + 1), n);
      chk("tick step", 16'(c0 + 16'h1), cnt);
    end
  endtask

  // the counter moves every 16 cycles here, so a capture may land one count late
  task automatic t_chan();
    logic [15:0] c0;
    logic        p0;
    int          n;
    sel_p = 2'h3;
    ch_sel = 1'b1;
    ch_clr = 8'hff;
    cyc(1);
    ch_clr = 8'h00;
    for (int ch = 0; ch < 4; ch++)
    begin
      c0 = cnt;
      cap_pin[ch] = 1'b1;
      n = 0;
      while (ch_flag[ch] !== 1'b1 && n < 10)
      begin
        cyc(1);
        n++;
      end
      chk("capture flag", 1, ch_flag[ch]);
      chk("capture value", 1, 16'(cap_val[ch] - c0) <= 16'h1);
    end
    ch_sel = 1'b0;
    ch_clr = 8'hff;
    cyc(1);
    ch_clr = 8'h00;
    for (int ch = 3; ch < 8; ch++)
    begin
      p0 = cmp_pin[ch];
      cmp_val[ch] = 16'(cnt + 16'h2);
      n = 0;
      while (ch_flag[ch] !== 1'b1 && n < 60)
      begin
        cyc(1);
        n++;
      end
      chk("compare flag", 1, ch_flag[ch]);
      chk("compare pin", !p0, cmp_pin[ch]);
    end
    cap_pin = 8'h00;
  endtask

  // one long run covers wrap, periodic rate and a serviced watchdog
  task automatic t_long();
    int n_ovf = 0;
    int n_per = 0;
    int per_at = 0;
    int n_wd = 0;
    int wd_at = 0;
    sel_p = 2'h0;
    wd_en = 1'b1;
    rstn = 1'b0;
    cyc(3);
    rstn = 1'b1;
    for (int i = 1; i <= 98400; i++)
    begin
      wd_srv = (i == 33000);
      // rate steps up one cycle after a pulse common to both rates
      sel_r  = (i > 65537) ? 2'h3 : (i > 32769) ? 2'h2 : (i > 16385) ? 2'h1 : 2'h0;
      cyc(1);
      n_ovf += int'(ovf_p === 1'b1);
      n_per += int'(per_i === 1'b1);
      if (per_i === 1'b1)
        per_at = i;
      if (wd_to === 1'b1)
      begin
        n_wd++;
        wd_at = i;
      end
    end
    chk("wraps", 1, n_ovf);
    chk("count after wrap", 32'h8060, cnt);
    chk("overflow flag", 1, ovf_f);
    chk("periodic pulses", 4, n_per);
    chk("last periodic", 65536, per_at);
    chk("watchdog fires", 1, n_wd);
    chk("watchdog time", 1, wd_at >= 65768 && wd_at <= 98538);
    ovf_clr = 1'b1;
    per_clr = 1'b1;
    cyc(1);
    ovf_clr = 1'b0;
    per_clr = 1'b0;
    wd_en = 1'b0;
    chk("overflow clear", 0, ovf_f);
    chk("periodic clear", 0, per_f);
  endtask

  task automatic t_mon();
    mon_en = 1'b1;
    repeat (8)
    begin
      cyc(20);
      mon_ref = ~mon_ref;
    end
    chk("monitor quiet", 0, clk_fail);
    repeat (8)
    begin
      cyc(2);
      mon_ref = ~mon_ref;
    end
    cyc(6);
    chk("monitor fail", 1, clk_fail);
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial
  begin
    {rstn, wd_en, wd_srv, ovf_clr, per_clr, ch_sel, mon_en, mon_ref} = 8'h00;
    {sel_p, sel_r, sel_w} = 6'h00;
    {cap_pin, ch_clr} = 16'h0000;
    cmp_val = '0;
    t_reset();
    t_prescale();
    t_chan();
    t_long();
    t_mon();
    conclude();
  end

  initial
  begin
    #1000000;
    n_mismatch++;
    conclude();
  end
endmodule

`default_nettype wire
